// ---- hdl/shpc_top.sv ----
// Added by the designer: the register addresses and strobed register access.
`include "shpc_map.svh"

module shpc_top (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_byte_en,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic i_acc_valid,
  input wire shpc_pkg::shpc_size_t i_acc_size,
  input wire logic [1:0] i_acc_addr_lo,
  input wire logic i_acc_multi,
  input wire logic i_trig_req,
  input wire logic i_trig_unpriv,
  output logic o_trig_allow,
  output logic o_trig_deny,
  input wire logic i_ret_req,
  input wire logic i_ret_to_thread,
  input wire logic i_ret_others_active,
  output logic o_ret_ok,
  output logic o_ret_fault,
  input wire logic i_fault_mem,
  input wire logic i_fault_bus,
  input wire logic i_fault_usg,
  input wire logic i_svc_call,
  output logic o_usage_fault,
  output logic o_hard_fault,
  input wire logic i_exc_enter,
  input wire shpc_pkg::shpc_exc_t i_enter_num,
  input wire logic i_exc_exit,
  input wire shpc_pkg::shpc_exc_t i_exit_num,
  input wire logic [2:0] i_prigroup,
  input wire logic [7:0] i_cur_prio,
  output logic o_preempt_req,
  output logic [3:0] o_preempt_num,
  output logic o_irq
);
  import shpc_pkg::*;

  // ==========================================
  // Helpers
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : lane_mask

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] be,
                                        input logic [31:0] impl);
    logic [31:0] m;
    m = lane_mask(be) & impl;
    merge = (old & ~m) | (wd & m);
  endfunction : merge

  // Only bits that are group priority take part
  function automatic logic [7:0] group_of(input logic [7:0] prio,
                                          input logic [2:0] pg);
    logic [7:0] m;
    m = 8'hff << ({1'b0, pg} + 4'h1);
    group_of = prio & m;
  endfunction : group_of

  function automatic logic [4:0] act_bit(input shpc_exc_t n);
    act_bit = 5'h1f;
    unique case (n)
      SHPC_EXC_MEM: act_bit = 5'h00;
      SHPC_EXC_BUS: act_bit = 5'h01;
      SHPC_EXC_USG: act_bit = 5'h03;
      SHPC_EXC_SVC: act_bit = 5'h07;
      SHPC_EXC_MON: act_bit = 5'h08;
      SHPC_EXC_PSV: act_bit = 5'h0a;
      SHPC_EXC_TICK: act_bit = 5'h0b;
      default: act_bit = 5'h1f;
    endcase
  endfunction : act_bit

  function automatic logic [4:0] pend_bit(input shpc_exc_t n);
    pend_bit = 5'h1f;
    unique case (n)
      SHPC_EXC_MEM: pend_bit = 5'(`SHPC_BIT_MEM_PEND);
      SHPC_EXC_BUS: pend_bit = 5'(`SHPC_BIT_BUS_PEND);
      SHPC_EXC_USG: pend_bit = 5'(`SHPC_BIT_USG_PEND);
      SHPC_EXC_SVC: pend_bit = 5'(`SHPC_BIT_SVC_PEND);
      default: pend_bit = 5'h1f;
    endcase
  endfunction : pend_bit

  // ==========================================
  // Register decode
  logic wr_ctrl;
  logic wr_prio1;
  logic wr_prio2;
  logic wr_prio3;
  logic wr_hcs;
  logic wr_stat;
  logic wr_mask;

  assign wr_ctrl = i_wr && (i_addr == `SHPC_OFS_CTRL);
  assign wr_prio1 = i_wr && (i_addr == `SHPC_OFS_PRIO1);
  assign wr_prio2 = i_wr && (i_addr == `SHPC_OFS_PRIO2);
  assign wr_prio3 = i_wr && (i_addr == `SHPC_OFS_PRIO3);
  assign wr_hcs = i_wr && (i_addr == `SHPC_OFS_HCS);
  assign wr_stat = i_wr && (i_addr == `SHPC_OFS_IRQ_STAT);
  assign wr_mask = i_wr && (i_addr == `SHPC_OFS_IRQ_MASK);

  logic [31:0] core_ctrl;
  logic [31:0] fault_handler_priority;
  logic [31:0] supervisor_call_priority;
  logic [31:0] tick_and_service_priority;
  logic [31:0] handler_control_state;
  logic [31:0] irq_status;
  logic [31:0] irq_mask;

  // ==========================================
  // Control and priority registers
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
      core_ctrl <= `SHPC_RESET;
    else if (wr_ctrl)
      core_ctrl <= merge(core_ctrl, i_wdata, i_byte_en, `SHPC_MASK_CTRL);
  end

  // Byte lanes let software touch one field alone
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
    begin
      fault_handler_priority <= `SHPC_RESET;
      supervisor_call_priority <= `SHPC_RESET;
      tick_and_service_priority <= `SHPC_RESET;
    end
    else
    begin
      if (wr_prio1)
        fault_handler_priority <= merge(fault_handler_priority, i_wdata,
                                        i_byte_en, `SHPC_MASK_PRIO1);
      if (wr_prio2)
        supervisor_call_priority <= merge(supervisor_call_priority, i_wdata,
                                          i_byte_en, `SHPC_MASK_PRIO2);
      if (wr_prio3)
        tick_and_service_priority <= merge(tick_and_service_priority, i_wdata,
                                           i_byte_en, `SHPC_MASK_PRIO3);
    end
  end

  logic trap_en;
  logic unpriv_ok;
  logic nested_ok;
  assign trap_en = core_ctrl[`SHPC_BIT_TRAP];
  assign unpriv_ok = core_ctrl[`SHPC_BIT_UNPRIV];
  assign nested_ok = core_ctrl[`SHPC_BIT_NESTED];

  // ==========================================
  // Unaligned access checking
  logic misaligned;
  logic unal_fault;
  always_comb
  begin
    misaligned = 1'b0;
    unique case (i_acc_size)
      SHPC_SZ_BYTE: misaligned = 1'b0;
      SHPC_SZ_HALF: misaligned = i_acc_addr_lo[0];
      SHPC_SZ_WORD: misaligned = |i_acc_addr_lo;
      SHPC_SZ_DWORD: misaligned = |i_acc_addr_lo;
    endcase
  end

  // Multiple and doubleword transfers ignore the trap setting
  assign unal_fault = i_acc_valid && misaligned &&
                      (i_acc_multi || (i_acc_size == SHPC_SZ_DWORD) ||
                       trap_en);

  // ==========================================
  // Fault routing
  logic mem_en;
  logic bus_en;
  logic usg_en;
  logic usg_event;
  logic escalate;
  assign mem_en = handler_control_state[`SHPC_BIT_MEM_EN];
  assign bus_en = handler_control_state[`SHPC_BIT_BUS_EN];
  assign usg_en = handler_control_state[`SHPC_BIT_USG_EN];
  assign usg_event = i_fault_usg || unal_fault;
  assign escalate = (i_fault_mem && !mem_en) || (i_fault_bus && !bus_en) ||
                    (usg_event && !usg_en);

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
    begin
      o_usage_fault <= 1'b0;
      o_hard_fault <= 1'b0;
    end
    else
    begin
      o_usage_fault <= unal_fault;
      o_hard_fault <= escalate;
    end
  end

  // ==========================================
  // Handler control and state
  logic [31:0] next_handler_state;
  always_comb
  begin
    next_handler_state = handler_control_state;
    if (wr_hcs)
      next_handler_state = merge(handler_control_state, i_wdata, i_byte_en,
                                 `SHPC_MASK_HCS);
    // Hardware applied last so an event beats a software clear
    if (i_exc_exit && act_bit(i_exit_num) != 5'h1f)
      next_handler_state[act_bit(i_exit_num)] = 1'b0;
    if (i_exc_enter && act_bit(i_enter_num) != 5'h1f)
      next_handler_state[act_bit(i_enter_num)] = 1'b1;
    if (i_exc_enter && pend_bit(i_enter_num) != 5'h1f)
      next_handler_state[pend_bit(i_enter_num)] = 1'b0;
    if (i_fault_mem && mem_en)
      next_handler_state[`SHPC_BIT_MEM_PEND] = 1'b1;
    if (i_fault_bus && bus_en)
      next_handler_state[`SHPC_BIT_BUS_PEND] = 1'b1;
    if (usg_event && usg_en)
      next_handler_state[`SHPC_BIT_USG_PEND] = 1'b1;
    if (i_svc_call)
      next_handler_state[`SHPC_BIT_SVC_PEND] = 1'b1;
  end

  // Active bits are taken as written; the stack is software's problem
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
      handler_control_state <= `SHPC_RESET;
    else
      handler_control_state <= next_handler_state;
  end

  // ==========================================
  // Software trigger access
  logic trig_deny_ev;
  assign trig_deny_ev = i_trig_req && i_trig_unpriv && !unpriv_ok;

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
    begin
      o_trig_allow <= 1'b0;
      o_trig_deny <= 1'b0;
    end
    else
    begin
      o_trig_allow <= i_trig_req && (!i_trig_unpriv || unpriv_ok);
      o_trig_deny <= trig_deny_ev;
    end
  end

  // ==========================================
  // Return to thread mode
  logic thr_fault_ev;
  assign thr_fault_ev = i_ret_req && i_ret_to_thread && !nested_ok &&
                        i_ret_others_active;

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
    begin
      o_ret_ok <= 1'b0;
      o_ret_fault <= 1'b0;
    end
    else
    begin
      o_ret_ok <= i_ret_req && !thr_fault_ev;
      o_ret_fault <= thr_fault_ev;
    end
  end

  // ==========================================
  // Preemption among pending handlers
  logic [3:0] cand_pend;
  logic [7:0] cand_prio [4];
  logic [3:0] cand_num [4];
  logic best_found;
  logic [7:0] best_grp;
  logic [3:0] best_num;

  assign cand_pend[0] = handler_control_state[`SHPC_BIT_MEM_PEND] && mem_en;
  assign cand_pend[1] = handler_control_state[`SHPC_BIT_BUS_PEND] && bus_en;
  assign cand_pend[2] = handler_control_state[`SHPC_BIT_USG_PEND] && usg_en;
  assign cand_pend[3] = handler_control_state[`SHPC_BIT_SVC_PEND];
  assign cand_prio[0] = fault_handler_priority[7:0];
  assign cand_prio[1] = fault_handler_priority[15:8];
  assign cand_prio[2] = fault_handler_priority[23:16];
  assign cand_prio[3] = supervisor_call_priority[31:24];
  assign cand_num[0] = SHPC_EXC_MEM;
  assign cand_num[1] = SHPC_EXC_BUS;
  assign cand_num[2] = SHPC_EXC_USG;
  assign cand_num[3] = SHPC_EXC_SVC;

  // Ties go to the lower exception number
  always_comb
  begin
    best_found = 1'b0;
    best_grp = 8'hff;
    best_num = 4'h0;
    for (int k = 0; k < 4; k++)
    begin
      if (cand_pend[k] &&
          (!best_found || group_of(cand_prio[k], i_prigroup) < best_grp))
      begin
        best_found = 1'b1;
        best_grp = group_of(cand_prio[k], i_prigroup);
        best_num = cand_num[k];
      end
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
    begin
      o_preempt_req <= 1'b0;
      o_preempt_num <= 4'h0;
    end
    else
    begin
      o_preempt_req <= best_found &&
                       (best_grp < group_of(i_cur_prio, i_prigroup));
      o_preempt_num <= best_num;
    end
  end

  // ==========================================
  // Interrupt status and mask
  logic [31:0] irq_events;
  always_comb
  begin
    irq_events = 32'h0;
    irq_events[`SHPC_BIT_IRQ_ESC] = escalate;
    irq_events[`SHPC_BIT_IRQ_UNAL] = unal_fault;
    irq_events[`SHPC_BIT_IRQ_DENY] = trig_deny_ev;
    irq_events[`SHPC_BIT_IRQ_THR] = thr_fault_ev;
  end

  // Write one to clear; a same-cycle event keeps the bit set
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
      irq_status <= `SHPC_RESET;
    else if (wr_stat)
      irq_status <= ((irq_status & ~(i_wdata & lane_mask(i_byte_en))) |
                     irq_events) & `SHPC_MASK_IRQ;
    else
      irq_status <= (irq_status | irq_events) & `SHPC_MASK_IRQ;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
      irq_mask <= `SHPC_RESET;
    else if (wr_mask)
      irq_mask <= merge(irq_mask, i_wdata, i_byte_en, `SHPC_MASK_IRQ);
  end

  // Irq follows status one cycle late, kept as a flop output
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
      o_irq <= 1'b0;
    else
      o_irq <= |(irq_status & irq_mask);
  end

  // ==========================================
  // Read path
  logic [31:0] next_rdata;
  always_comb
  begin
    next_rdata = 32'h0;
    if (i_rd)
    begin
      unique case (i_addr)
        `SHPC_OFS_CTRL: next_rdata = core_ctrl;
        `SHPC_OFS_PRIO1: next_rdata = fault_handler_priority;
        `SHPC_OFS_PRIO2: next_rdata = supervisor_call_priority;
        `SHPC_OFS_PRIO3: next_rdata = tick_and_service_priority;
        `SHPC_OFS_HCS: next_rdata = handler_control_state;
        `SHPC_OFS_IRQ_STAT: next_rdata = irq_status;
        `SHPC_OFS_IRQ_MASK: next_rdata = irq_mask;
        default: next_rdata = 32'h0;
      endcase
    end
  end

  // Data stand only in the cycle after the strobe
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
      o_rdata <= 32'h0;
    else
      o_rdata <= next_rdata;
  end
endmodule : shpc_top

// ---- common/shpc_map.svh ----
`ifndef SHPC_MAP_SVH
`define SHPC_MAP_SVH

// ==========================================
// Register offsets
`define SHPC_OFS_CTRL 8'h00
`define SHPC_OFS_PRIO1 8'h04
`define SHPC_OFS_PRIO2 8'h08
`define SHPC_OFS_PRIO3 8'h0c
`define SHPC_OFS_HCS 8'h10
`define SHPC_OFS_IRQ_STAT 8'h14
`define SHPC_OFS_IRQ_MASK 8'h18

// ==========================================
// Implemented bits and reset value
`define SHPC_MASK_CTRL 32'h0000000b
`define SHPC_MASK_PRIO1 32'h00f0f0f0
`define SHPC_MASK_PRIO2 32'hf0000000
`define SHPC_MASK_PRIO3 32'hf0f00000
`define SHPC_MASK_HCS 32'h0007fd8b
`define SHPC_MASK_IRQ 32'h0000000f
`define SHPC_RESET 32'h00000000

// ==========================================
// Field positions
`define SHPC_BIT_NESTED 0
`define SHPC_BIT_UNPRIV 1
`define SHPC_BIT_TRAP 3
`define SHPC_BIT_USG_EN 18
`define SHPC_BIT_BUS_EN 17
`define SHPC_BIT_MEM_EN 16
`define SHPC_BIT_SVC_PEND 15
`define SHPC_BIT_BUS_PEND 14
`define SHPC_BIT_MEM_PEND 13
`define SHPC_BIT_USG_PEND 12
`define SHPC_BIT_IRQ_ESC 0
`define SHPC_BIT_IRQ_UNAL 1
`define SHPC_BIT_IRQ_DENY 2
`define SHPC_BIT_IRQ_THR 3
`endif

// ---- common/shpc_pkg.sv ----
package shpc_pkg;
  typedef enum logic [1:0] {
    SHPC_SZ_BYTE = 2'b00,
    SHPC_SZ_HALF = 2'b01,
    SHPC_SZ_WORD = 2'b10,
    SHPC_SZ_DWORD = 2'b11
  } shpc_size_t;
  typedef enum logic [3:0] {
    SHPC_EXC_MEM = 4'h4,
    SHPC_EXC_BUS = 4'h5,
    SHPC_EXC_USG = 4'h6,
    SHPC_EXC_SVC = 4'hb,
    SHPC_EXC_MON = 4'hc,
    SHPC_EXC_PSV = 4'he,
    SHPC_EXC_TICK = 4'hf
  } shpc_exc_t;
endpackage : shpc_pkg

// ---- testbench/shpc_top_sva.sv ----
`include "shpc_map.svh"

// ==========================================
// Port checks
module shpc_top_sva
  import shpc_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic [7:0] i_addr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic i_acc_valid,
  input wire shpc_pkg::shpc_size_t i_acc_size,
  input wire logic [1:0] i_acc_addr_lo,
  input wire logic i_acc_multi,
  input wire logic o_usage_fault,
  input wire logic i_trig_req,
  input wire logic i_trig_unpriv,
  input wire logic o_trig_allow,
  input wire logic o_trig_deny,
  input wire logic i_ret_req,
  input wire logic i_ret_others_active,
  input wire logic o_ret_ok,
  input wire logic o_ret_fault
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rstn);
  sequence s_read(logic [7:0] a);
    i_rd && i_addr == a;
  endsequence
  sequence s_unal(shpc_size_t s);
    i_acc_valid && i_acc_size == s && i_acc_addr_lo != 2'h0;
  endsequence
  a_prio1_resv: assert property (s_read(8'h04) |=> (o_rdata & 32'hff0f0f0f) == 32'h0)
    else $error("prio1 reserved bits set");
  a_prio2_resv: assert property (s_read(8'h08) |=> (o_rdata & 32'h0fffffff) == 32'h0)
    else $error("prio2 reserved bits set");
  a_prio3_resv: assert property (s_read(8'h0c) |=> (o_rdata & 32'h0f0fffff) == 32'h0)
    else $error("prio3 reserved bits set");
  a_hcs_resv: assert property (s_read(8'h10) |=> (o_rdata & 32'hfff80274) == 32'h0)
    else $error("handler state reserved bits set");
  a_multi_fault: assert property (s_unal(SHPC_SZ_WORD) ##0 i_acc_multi |=> o_usage_fault)
    else $error("unaligned multiple did not fault");
  a_dword_fault: assert property (s_unal(SHPC_SZ_DWORD) |=> o_usage_fault)
    else $error("unaligned doubleword did not fault");
  a_aligned_ok: assert property (i_acc_valid && (i_acc_addr_lo == 2'h0 ||
    i_acc_size == SHPC_SZ_BYTE) |=> !o_usage_fault)
    else $error("aligned access faulted");
  a_trig_one: assert property (i_trig_req |=> o_trig_allow ^ o_trig_deny)
    else $error("trigger answer not exclusive");
  a_trig_priv: assert property (i_trig_req && !i_trig_unpriv |=> o_trig_allow)
    else $error("privileged trigger refused");
  a_ret_base: assert property (i_ret_req && !i_ret_others_active |=> o_ret_ok && !o_ret_fault)
    else $error("return with none active refused");
endmodule : shpc_top_sva

bind shpc_top shpc_top_sva shpc_top_sva_inst (.i_core_clk(i_core_clk), .i_rstn(i_rstn),
  .i_addr(i_addr), .i_rd(i_rd), .o_rdata(o_rdata), .i_acc_valid(i_acc_valid),
  .i_acc_size(i_acc_size), .i_acc_addr_lo(i_acc_addr_lo), .i_acc_multi(i_acc_multi),
  .o_usage_fault(o_usage_fault), .i_trig_req(i_trig_req), .i_trig_unpriv(i_trig_unpriv),
  .o_trig_allow(o_trig_allow), .o_trig_deny(o_trig_deny), .i_ret_req(i_ret_req),
  .i_ret_others_active(i_ret_others_active), .o_ret_ok(o_ret_ok), .o_ret_fault(o_ret_fault));

// ---- testbench/shpc_top_tb.sv ----
// ==========================================
// Bench
module shpc_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import shpc_pkg::*;
  logic i_core_clk, i_rstn, i_wr, i_rd, i_acc_valid, i_acc_multi, i_trig_req, i_trig_unpriv;
  logic i_ret_req, i_ret_to_thread, i_ret_others_active, i_fault_mem, i_fault_bus;
  logic i_exc_enter, o_trig_allow, o_trig_deny, o_ret_ok, o_ret_fault, o_usage_fault;
  logic o_hard_fault, o_preempt_req, o_irq;
  logic i_fault_usg, i_svc_call, i_exc_exit;
  logic [7:0] i_addr, i_cur_prio;
  logic [31:0] i_wdata, o_rdata;
  logic [3:0] i_byte_en, o_preempt_num;
  logic [1:0] i_acc_addr_lo;
  logic [2:0] i_prigroup;
  shpc_size_t i_acc_size;
  shpc_exc_t i_enter_num;
  shpc_exc_t i_exit_num;
  int err_total = 0;
  int tests_run = 0;
  // Bits: trap, size, low address, multiple, fault expected
  localparam logic [6:0] UNAL [8] = '{7'b0010100, 7'b0101000, 7'b0100111, 7'b0111001,
    7'b1010101, 7'b1101101, 7'b1000100, 7'b1100000};

  shpc_top shpc_top_inst (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_byte_en(i_byte_en), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_acc_valid(i_acc_valid), .i_acc_size(i_acc_size), .i_acc_addr_lo(i_acc_addr_lo),
    .i_acc_multi(i_acc_multi), .i_trig_req(i_trig_req), .i_trig_unpriv(i_trig_unpriv),
    .o_trig_allow(o_trig_allow), .o_trig_deny(o_trig_deny), .i_ret_req(i_ret_req),
    .i_ret_to_thread(i_ret_to_thread), .i_ret_others_active(i_ret_others_active),
    .o_ret_ok(o_ret_ok), .o_ret_fault(o_ret_fault), .i_fault_mem(i_fault_mem),
    .i_fault_bus(i_fault_bus), .i_fault_usg(i_fault_usg), .i_svc_call(i_svc_call),
    .o_usage_fault(o_usage_fault), .o_hard_fault(o_hard_fault), .i_exc_enter(i_exc_enter),
    .i_enter_num(i_enter_num), .i_exc_exit(i_exc_exit), .i_exit_num(i_exit_num),
    .i_prigroup(i_prigroup), .i_cur_prio(i_cur_prio), .o_preempt_req(o_preempt_req),
    .o_preempt_num(o_preempt_num), .o_irq(o_irq));

  initial
  begin
    i_core_clk = 1'b0;
    forever #20 i_core_clk = ~i_core_clk;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim

  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic wr(logic [7:0] a, logic [31:0] d, logic [3:0] be = 4'hf);
    @(posedge i_core_clk);
    i_addr <= a;
    i_wdata <= d;
    i_byte_en <= be;
    i_wr <= 1'b1;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask : wr

  task automatic rd(string n, logic [7:0] a, logic [31:0] e);
    @(posedge i_core_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1 chk(n, o_rdata, e);
  endtask : rd

  task automatic settle();
    repeat (2) @(posedge i_core_clk);
    #1;
  endtask : settle

  task automatic test_regs();
    for (int i = 0; i < 7; i++)
      rd("reset value", 8'(i * 4), 32'h0);
    wr(8'h04, 32'hffffffff);
    rd("prio1", 8'h04, 32'h00f0f0f0);
    wr(8'h08, 32'hffffffff);
    rd("prio2", 8'h08, 32'hf0000000);
    wr(8'h0c, 32'hffffffff);
    rd("prio3", 8'h0c, 32'hf0f00000);
    wr(8'h10, 32'hffffffff);
    rd("handler state", 8'h10, 32'h0007fd8b);
    wr(8'h04, 32'h0);
    wr(8'h04, 32'hffffffff, 4'h2);
    rd("prio1 byte", 8'h04, 32'h0000f000);
    wr(8'h40, 32'hffffffff);
    rd("unmapped", 8'h40, 32'h0);
  endtask : test_regs

  task automatic test_unal();
    foreach (UNAL[i])
    begin
      wr(8'h00, {28'h0, UNAL[i][6], 3'h0});
      @(posedge i_core_clk);
      i_acc_valid <= 1'b1;
      i_acc_size <= shpc_size_t'(UNAL[i][5:4]);
      i_acc_addr_lo <= UNAL[i][3:2];
      i_acc_multi <= UNAL[i][1];
      @(posedge i_core_clk);
      i_acc_valid <= 1'b0;
      #1 chk("usage fault", 32'(o_usage_fault), 32'(UNAL[i][0]));
    end
  endtask : test_unal

  task automatic trig(logic u, logic a);
    @(posedge i_core_clk);
    i_trig_req <= 1'b1;
    i_trig_unpriv <= u;
    @(posedge i_core_clk);
    i_trig_req <= 1'b0;
    #1 chk("trig allow", 32'(o_trig_allow), 32'(a));
    chk("trig deny", 32'(o_trig_deny), 32'(!a));
  endtask : trig

  task automatic test_trig();
    wr(8'h00, 32'h0);
    wr(8'h18, 32'h0);
    wr(8'h14, 32'hf);
    trig(1'b0, 1'b1);
    trig(1'b1, 1'b0);
    rd("irq status", 8'h14, 32'h4);
    chk("irq masked", 32'(o_irq), 32'h0);
    wr(8'h18, 32'h4);
    settle();
    chk("irq raised", 32'(o_irq), 32'h1);
    wr(8'h14, 32'h4);
    settle();
    chk("irq cleared", 32'(o_irq), 32'h0);
    wr(8'h00, 32'h2);
    trig(1'b1, 1'b1);
  endtask : test_trig

  task automatic ret(logic o, logic ok);
    @(posedge i_core_clk);
    i_ret_req <= 1'b1;
    i_ret_others_active <= o;
    @(posedge i_core_clk);
    i_ret_req <= 1'b0;
    #1 chk("ret ok", 32'(o_ret_ok), 32'(ok));
    chk("ret fault", 32'(o_ret_fault), 32'(!ok));
  endtask : ret

  task automatic test_ret();
    wr(8'h00, 32'h0);
    ret(1'b1, 1'b0);
    ret(1'b0, 1'b1);
    wr(8'h00, 32'h1);
    ret(1'b1, 1'b1);
    // Return to a handler never faults, even with others active
    wr(8'h00, 32'h0);
    @(posedge i_core_clk);
    i_ret_to_thread <= 1'b0;
    ret(1'b1, 1'b1);
  endtask : test_ret

  task automatic fault(logic m, logic b, logic h);
    @(posedge i_core_clk);
    i_fault_mem <= m;
    i_fault_bus <= b;
    @(posedge i_core_clk);
    i_fault_mem <= 1'b0;
    i_fault_bus <= 1'b0;
    #1 chk("hard fault", 32'(o_hard_fault), 32'(h));
  endtask : fault

  task automatic test_faults();
    wr(8'h10, 32'h0);
    wr(8'h04, 32'h00004000);
    fault(1'b1, 1'b0, 1'b1);
    wr(8'h10, 32'h00020000);
    fault(1'b0, 1'b1, 1'b0);
    rd("bus pending", 8'h10, 32'h00024000);
    @(posedge i_core_clk);
    i_prigroup <= 3'h3;
    i_cur_prio <= 8'h48;
    settle();
    chk("same group", 32'(o_preempt_req), 32'h0);
    @(posedge i_core_clk);
    i_prigroup <= 3'h2;
    settle();
    chk("higher group", 32'(o_preempt_req), 32'h1);
    chk("preempt num", 32'(o_preempt_num), 32'h5);
    @(posedge i_core_clk);
    i_exc_enter <= 1'b1;
    i_enter_num <= SHPC_EXC_BUS;
    @(posedge i_core_clk);
    i_exc_enter <= 1'b0;
    rd("bus active", 8'h10, 32'h00020002);
    @(posedge i_core_clk);
    i_exc_exit <= 1'b1;
    i_exit_num <= SHPC_EXC_BUS;
    i_svc_call <= 1'b1;
    i_fault_usg <= 1'b1;
    @(posedge i_core_clk);
    i_exc_exit <= 1'b0;
    i_svc_call <= 1'b0;
    i_fault_usg <= 1'b0;
    #1 chk("usage escalated", 32'(o_hard_fault), 32'h1);
    rd("svc pending", 8'h10, 32'h00028000);
  endtask : test_faults

  initial
  begin
    repeat (5000) @(posedge i_core_clk);
    err_total++;
    end_sim();
  end

  initial
  begin
    {i_rstn, i_wr, i_rd, i_acc_valid, i_acc_multi, i_trig_req, i_trig_unpriv} = '0;
    {i_ret_req, i_ret_others_active, i_fault_mem, i_fault_bus, i_exc_enter} = '0;
    {i_fault_usg, i_svc_call, i_exc_exit} = '0;
    i_exit_num = SHPC_EXC_MEM;
    i_ret_to_thread = 1'b1;
    {i_addr, i_cur_prio, i_wdata, i_byte_en, i_acc_addr_lo, i_prigroup} = '0;
    i_acc_size = SHPC_SZ_BYTE;
    i_enter_num = SHPC_EXC_MEM;
    repeat (10) @(posedge i_core_clk);
    i_rstn <= 1'b1;
    test_regs();
    test_unal();
    test_trig();
    test_ret();
    test_faults();
    end_sim();
  end
endmodule : shpc_top_tb
